// [srf_pkg.sv]
package srf_pkg;
  localparam int BYTE_BITS = 8;
  localparam int PATTERN_BITS = 48;
  localparam int PHASE_BITS = 3;
  localparam int FRAME_COUNT_BITS = 16;
  // Three A1 bytes then three A2 bytes, first bit in the top position
  localparam logic [47:0] FRAME_PATTERN = 48'hf6f6f6282828;
  // Bit position within the held byte alignment
  localparam logic [2:0] PHASE_LAST = 3'h7;
  localparam logic [2:0] PHASE_RESET = 3'h0;
  // Free-running byte clock divider: high for counts 0 to 3, low for 4 to 7
  localparam logic [2:0] BCLK_CNT_RESET = 3'h0;
  localparam logic [2:0] BCLK_HIGH_LAST = 3'h3;
  localparam logic BCLK_RESET = 1'b1;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] FRAME_COUNT_RESET = 16'h0000;
  // Byte clock rates per line rate and bus width, in kHz
  localparam int RATE_STM1_BUS8_KHZ = 19440;
  localparam int RATE_STM1_BUS4_KHZ = 38880;
  localparam int RATE_STM4_BUS8_KHZ = 77760;
  localparam int RATE_STM4_BUS4_KHZ = 155520;
  typedef enum logic [1:0] {SRF_IDLE, SRF_HUNT, SRF_CONFIRM} srf_state_e;
endpackage

// [srf_match_if.sv]
`timescale 1ns/1ps
interface srf_match_if;
  logic serial_bit;
  logic [srf_pkg::BYTE_BITS-1:0] last_byte;
  logic match;
  modport window
  (
    input serial_bit,
    output last_byte,
    output match
  );
  modport user
  (
    output serial_bit,
    input last_byte,
    input match
  );
endinterface

// [srf_pattern_window.sv]
`timescale 1ns/1ps
module srf_pattern_window #(
  parameter int PATTERN_BITS = srf_pkg::PATTERN_BITS,
  parameter logic [PATTERN_BITS-1:0] PATTERN = srf_pkg::FRAME_PATTERN
)
(
  input wire logic sclk,
  input wire logic srst_n,
  srf_match_if.window win
);
  import srf_pkg::*;

  logic [PATTERN_BITS-1:0] window_bits;

  // Oldest bit at the top, so the first bit of a byte lands on the MSB
  always_ff @(posedge sclk)
  begin
    if (!srst_n)
      window_bits <= '0;
    else
      window_bits <= {window_bits[PATTERN_BITS-2:0], win.serial_bit};
  end

  // Compared at every bit, so any bit offset is found
  assign win.match = (window_bits == PATTERN);
  assign win.last_byte = window_bits[BYTE_BITS-1:0];
endmodule

// [srf_rx_framer_loopback.sv]
`timescale 1ns/1ps
module srf_rx_framer_loopback
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  input wire logic rx_serial_in,
  input wire logic rx_serial_clk_in,
  input wire logic p2s_serial_data,
  input wire logic p2s_serial_clk,
  input wire logic diag_loopback_n,
  input wire logic line_loopback_n,
  input wire logic frame_search_request,
  output logic tx_serial_out,
  output logic tx_serial_clk_out,
  output logic rx_byte_clock,
  output logic [srf_pkg::BYTE_BITS-1:0] rx_parallel_bus,
  output logic frame_pulse,
  output logic search_active,
  output logic frame_event,
  output logic [srf_pkg::FRAME_COUNT_BITS-1:0] frame_count
);
  import srf_pkg::*;

  // Loopback routing, no registers: these paths run at serial rate
  logic deser_clk;
  logic deser_bit;

  // Each selector looks only at its own enable, so both may be low at once
  assign deser_bit = diag_loopback_n ? rx_serial_in : p2s_serial_data;
  assign deser_clk = diag_loopback_n ? rx_serial_clk_in : p2s_serial_clk;

  always_comb
  begin
    if (line_loopback_n)
    begin
      tx_serial_out = p2s_serial_data;
      tx_serial_clk_out = p2s_serial_clk;
    end
    else
    begin
      tx_serial_out = rx_serial_in;
      tx_serial_clk_out = rx_serial_clk_in;
    end
  end

  // Serial domain reset; needs the serial clock running while held
  logic srst_meta;
  logic srst_n;

  always_ff @(posedge deser_clk)
  begin
    srst_meta <= resetn;
    srst_n <= srst_meta;
  end

  // Search request crossing into the serial domain
  logic req_meta;
  logic req_sync;
  logic req_prev;
  logic req_rise;

  always_ff @(posedge deser_clk)
  begin
    if (!srst_n)
    begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_prev <= 1'b0;
    end
    else
    begin
      req_meta <= frame_search_request;
      req_sync <= req_meta;
      req_prev <= req_sync;
    end
  end

  // Minimum width of one byte clock keeps the pulse visible after two stages
  assign req_rise = req_sync && !req_prev;

  // Pattern window
  srf_match_if mif();

  assign mif.serial_bit = deser_bit;

  srf_pattern_window #(
    .PATTERN_BITS(PATTERN_BITS),
    .PATTERN(FRAME_PATTERN)
  ) u_window (
    .sclk(deser_clk),
    .srst_n(srst_n),
    .win(mif.window)
  );

  // Search state and byte alignment
  srf_state_e state;
  srf_state_e next_state;
  logic hunting;
  logic [PHASE_BITS-1:0] phase;
  logic byte_done;
  logic capture;
  logic fp_found;

  assign hunting = (state != SRF_IDLE);
  assign byte_done = (phase == PHASE_LAST);
  // Any offset while hunting; only the held boundary otherwise
  assign fp_found = mif.match && (hunting || byte_done);
  assign capture = byte_done || fp_found;

  always_comb
  begin
    next_state = state;
    unique case (state)
      SRF_IDLE:
        next_state = SRF_IDLE;
      SRF_HUNT:
      begin
        if (fp_found && !req_sync)
          next_state = SRF_IDLE;
        else if (fp_found)
          next_state = SRF_CONFIRM;
      end
      SRF_CONFIRM:
      begin
        if (!req_sync)
          next_state = SRF_IDLE;
      end
      // Unused code falls back to idle
      default:
        next_state = SRF_IDLE;
    endcase
    // A new rising edge restarts the hunt from any state
    if (req_rise)
      next_state = SRF_HUNT;
  end

  always_ff @(posedge deser_clk)
  begin
    if (!srst_n)
      state <= SRF_IDLE;
    else
      state <= next_state;
  end

  // Only a hunting match moves the boundary; otherwise it is held
  always_ff @(posedge deser_clk)
  begin
    if (!srst_n)
      phase <= PHASE_RESET;
    else if (hunting && mif.match)
      phase <= PHASE_RESET;
    else
      phase <= phase + 1'b1;
  end

  // Hold stage between alignment and the byte clock launch
  logic [BYTE_BITS-1:0] held_byte;
  logic held_fp;
  logic launch;

  always_ff @(posedge deser_clk)
  begin
    if (!srst_n)
      held_byte <= BYTE_RESET;
    else if (capture)
      held_byte <= mif.last_byte;
  end

  // Found frame waits for a later launch, so the pulse goes out with its own byte
  always_ff @(posedge deser_clk)
  begin
    if (!srst_n)
      held_fp <= 1'b0;
    else if (capture && fp_found)
      held_fp <= 1'b1;
    else if (launch)
      held_fp <= 1'b0;
  end

  // Free-running byte clock, independent of the alignment phase
  logic [PHASE_BITS-1:0] bclk_cnt;
  logic [PHASE_BITS-1:0] next_bclk_cnt;
  logic next_bclk;

  assign next_bclk_cnt = bclk_cnt + 1'b1;
  assign next_bclk = (next_bclk_cnt <= BCLK_HIGH_LAST);
  assign launch = rx_byte_clock && !next_bclk;

  // Realignment never touches this counter, so no short or long cycle
  always_ff @(posedge deser_clk)
  begin
    if (!srst_n)
    begin
      bclk_cnt <= BCLK_CNT_RESET;
      rx_byte_clock <= BCLK_RESET;
    end
    else
    begin
      bclk_cnt <= next_bclk_cnt;
      rx_byte_clock <= next_bclk;
    end
  end

  // Outputs move only in the edge that takes the byte clock low
  always_ff @(posedge deser_clk)
  begin
    if (!srst_n)
    begin
      rx_parallel_bus <= BYTE_RESET;
      frame_pulse <= 1'b0;
    end
    else if (launch)
    begin
      rx_parallel_bus <= held_byte;
      frame_pulse <= held_fp;
    end
  end

  // Events toward the clock domain
  logic fp_toggle;
  logic active_level;

  always_ff @(posedge deser_clk)
  begin
    if (!srst_n)
    begin
      fp_toggle <= 1'b0;
      active_level <= 1'b0;
    end
    else
    begin
      if (launch && held_fp)
        fp_toggle <= !fp_toggle;
      active_level <= hunting;
    end
  end

  // Clock domain status, frozen while clock_enable is low
  logic act_meta;
  logic tog_meta;
  logic tog_sync;
  logic tog_prev;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      act_meta <= 1'b0;
      search_active <= 1'b0;
    end
    else if (clock_enable)
    begin
      act_meta <= active_level;
      search_active <= act_meta;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_prev <= 1'b0;
    end
    else if (clock_enable)
    begin
      tog_meta <= fp_toggle;
      tog_sync <= tog_meta;
      tog_prev <= tog_sync;
    end
  end

  // Frame pulses closer than two clock periods would merge; not possible at 125 us frames
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      frame_event <= 1'b0;
      frame_count <= FRAME_COUNT_RESET;
    end
    else if (clock_enable)
    begin
      frame_event <= tog_sync ^ tog_prev;
      if (tog_sync ^ tog_prev)
        frame_count <= frame_count + 1'b1;
    end
  end
endmodule

// [srf_rx_framer_loopback_sva.sv]
`timescale 1ns/1ps
module srf_rx_framer_loopback_sva
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic rx_serial_in,
  input wire logic rx_serial_clk_in,
  input wire logic p2s_serial_data,
  input wire logic p2s_serial_clk,
  input wire logic line_loopback_n,
  input wire logic frame_search_request,
  input wire logic tx_serial_out,
  input wire logic tx_serial_clk_out,
  input wire logic rx_byte_clock,
  input wire logic [srf_pkg::BYTE_BITS-1:0] rx_parallel_bus,
  input wire logic frame_pulse,
  input wire logic search_active
);
  import srf_pkg::*;
  sequence pulse_run;
    frame_pulse [*8] ##1 !frame_pulse;
  endsequence
  sequence byte_period;
    !rx_byte_clock [*4] ##1 rx_byte_clock [*4] ##1 !rx_byte_clock;
  endsequence
  bus_on_fall_a: assert property (@(posedge rx_serial_clk_in) disable iff (!resetn)
    $changed(rx_parallel_bus) |-> $fell(rx_byte_clock)) else $error("bus moved off fall");
  pulse_on_fall_a: assert property (@(posedge rx_serial_clk_in) disable iff (!resetn)
    $changed(frame_pulse) |-> $fell(rx_byte_clock)) else $error("pulse moved off fall");
  pulse_width_a: assert property (@(posedge rx_serial_clk_in) disable iff (!resetn)
    $rose(frame_pulse) |-> pulse_run) else $error("pulse not one byte");
  byte_duty_a: assert property (@(posedge rx_serial_clk_in) disable iff (!resetn)
    $fell(rx_byte_clock) |-> byte_period) else $error("byte clock uneven");
  pulse_byte_a: assert property (@(posedge rx_serial_clk_in) disable iff (!resetn)
    $rose(frame_pulse) |-> rx_parallel_bus == FRAME_PATTERN[BYTE_BITS-1:0])
    else $error("pulse on wrong byte");
  tx_data_mux_a: assert property (@(posedge clock) disable iff (!resetn)
    tx_serial_out == (line_loopback_n ? p2s_serial_data : rx_serial_in)) else $error("tx data");
  tx_clk_mux_a: assert property (@(posedge clock) disable iff (!resetn)
    tx_serial_clk_out == (line_loopback_n ? p2s_serial_clk : rx_serial_clk_in)) else $error("tx clk");
  search_start_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(frame_search_request) |-> ##[1:10] search_active) else $error("search not started");
endmodule
bind srf_rx_framer_loopback srf_rx_framer_loopback_sva srf_rx_framer_loopback_sva_inst
  (.clock(clock), .resetn(resetn), .rx_serial_in(rx_serial_in),
  .rx_serial_clk_in(rx_serial_clk_in), .p2s_serial_data(p2s_serial_data),
  .p2s_serial_clk(p2s_serial_clk), .line_loopback_n(line_loopback_n),
  .frame_search_request(frame_search_request), .tx_serial_out(tx_serial_out),
  .tx_serial_clk_out(tx_serial_clk_out), .rx_byte_clock(rx_byte_clock),
  .rx_parallel_bus(rx_parallel_bus), .frame_pulse(frame_pulse), .search_active(search_active));

// [srf_downstream.sv]
`timescale 1ns/1ps
module srf_downstream #(
  parameter int FRAME_BYTES = 24
)
(
  input wire logic byte_clk,
  input wire logic [7:0] bus,
  input wire logic pulse,
  input wire logic want,
  output logic req,
  output logic [7:0] seen,
  output logic [7:0] after
);
  int n = 0;
  logic was = 1'b0;
  // Held one frame so alignment can be verified before release
  assign req = want | (n > 0);
  always @(posedge byte_clk)
  begin
    was <= pulse;
    if (pulse) seen <= bus;
    if (was) after <= bus;
    if (pulse && req && n == 0) n <= FRAME_BYTES;
    else if (n > 0) n <= n - 1;
  end
endmodule

// [srf_rx_framer_loopback_bench.sv]
`timescale 1ns/1ps
module srf_rx_framer_loopback_bench;
  import srf_pkg::*;
  logic clock = 1'b0, sclk = 1'b0, resetn = 1'b0, rx_serial_in = 1'b0, p2s_serial_data = 1'b1;
  logic diag_loopback_n = 1'b1, line_loopback_n = 1'b1, want = 1'b0, clock_enable = 1'b1;
  logic frame_search_request, tx_serial_out, tx_serial_clk_out, rx_byte_clock, frame_pulse;
  logic search_active, frame_event;
  logic [7:0] rx_parallel_bus, seen, after;
  logic [15:0] frame_count;
  wire logic p2s_serial_clk;
  int miscompares = 0, checks_done = 0, cyc = 0, events = 0;
  // Delayed copy: apart at every other tx clock check sample, equal at the diag switch
  assign #8 p2s_serial_clk = sclk;
  srf_rx_framer_loopback srf_rx_framer_loopback_inst (.clock(clock), .resetn(resetn),
    .clock_enable(clock_enable), .rx_serial_in(rx_serial_in), .rx_serial_clk_in(sclk),
    .p2s_serial_data(p2s_serial_data), .p2s_serial_clk(p2s_serial_clk),
    .diag_loopback_n(diag_loopback_n), .line_loopback_n(line_loopback_n),
    .frame_search_request(frame_search_request), .tx_serial_out(tx_serial_out),
    .tx_serial_clk_out(tx_serial_clk_out), .rx_byte_clock(rx_byte_clock),
    .rx_parallel_bus(rx_parallel_bus), .frame_pulse(frame_pulse),
    .search_active(search_active), .frame_event(frame_event), .frame_count(frame_count));
  srf_downstream srf_downstream_inst (.byte_clk(rx_byte_clock), .bus(rx_parallel_bus),
    .pulse(frame_pulse), .want(want), .req(frame_search_request), .seen(seen), .after(after));
  initial
  begin
    forever #20 clock = ~clock;
  end
  initial
  begin
    #7;
    forever #16 sclk = ~sclk;
  end
  task automatic stop_test();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Unused source carries the inverse, so a wrong path selection shows
  task automatic bit_out(input logic b);
    @(negedge sclk);
    rx_serial_in <= b ^ !diag_loopback_n;
    p2s_serial_data <= ~(b ^ !diag_loopback_n);
  endtask
  task automatic byte_out(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
  endtask
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) byte_out(8'h00);
  endtask
  task automatic frame_out(input logic [7:0] pay);
    for (int i = 47; i >= 0; i--) bit_out(FRAME_PATTERN[i]);
    byte_out(pay);
    fill(3);
  endtask
  task automatic ask(input logic v);
    @(negedge clock);
    want = v;
  endtask
  task automatic flag(input logic exp);
    chk({15'h0000, search_active}, {15'h0000, exp});
  endtask
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      miscompares++;
      stop_test();
    end
  end
  // Sampled mid-cycle, away from the edge that launches it
  always @(negedge clock)
  begin
    if (frame_event === 1'b1)
      events <= events + 1;
  end
  initial
  begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    fill(2);
    ask(1'b1);
    fill(2);
    repeat (3) bit_out(1'b0);
    frame_out(8'hc1);
    ask(1'b0);
    chk({8'h00, seen}, 16'h0028);
    chk({8'h00, after}, 16'h00c1);
    chk(frame_count, 16'h0001);
    fill(8);
    flag(1'b1);
    fill(24);
    flag(1'b0);
    frame_out(8'h3c);
    chk(frame_count, 16'h0002);
    bit_out(1'b0);
    frame_out(8'h3c);
    chk(frame_count, 16'h0002);
    ask(1'b1);
    fill(2);
    ask(1'b0);
    fill(4);
    flag(1'b1);
    frame_out(8'h3c);
    chk(frame_count, 16'h0003);
    flag(1'b0);
    @(negedge clock);
    // Switch only while both serial clocks agree, so no stray deserializer edge
    if (($time % 80) != 0)
      @(negedge clock);
    diag_loopback_n = 1'b0;
    line_loopback_n = 1'b0;
    ask(1'b1);
    fill(2);
    frame_out(8'ha5);
    ask(1'b0);
    chk({8'h00, after}, 16'h00a5);
    chk(frame_count, 16'h0004);
    fill(30);
    @(negedge clock);
    clock_enable = 1'b0;
    frame_out(8'h5a);
    chk(frame_count, 16'h0004);
    @(negedge clock);
    clock_enable = 1'b1;
    repeat (6) @(negedge clock);
    chk(frame_count, 16'h0005);
    chk(events[15:0], 16'h0005);
    stop_test();
  end
endmodule
